// ==== common/diag_pkg.sv ====
// Constants, types and carriers for the LED chain diagnostic sequencer.
// Assumes a single 40 MHz clock and an AXI4-Lite register port.
package diag_pkg;

  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int NUM_CH = 16;
  localparam int CLK_MHZ = 40;
  localparam int STEP_NS = 20;
  localparam int STEP_CYC_RAW = (STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int STEP_CYC = (STEP_CYC_RAW < 1) ? 1 : STEP_CYC_RAW;
  localparam int CNT_W = 5;

  // ****************************************
  // Mode pulse counts
  // ****************************************
  localparam logic [2:0] PULSES_OPEN = 3'h1;
  localparam logic [2:0] PULSES_SHORT = 3'h2;
  localparam logic [2:0] PULSES_LOWCUR = 3'h3;
  localparam logic [2:0] PULSES_MAX = 3'h7;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_DISPLAY = 4'h8;
  localparam logic [3:0] OFS_REPORT = 4'hC;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
  localparam logic [14:0] TEMP_FILL = 15'h7FFF;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_ARMED  = 2'h1,
    MODE_TEST   = 2'h3,
    MODE_DONE   = 2'h2
  } mode_e;

  typedef enum logic [1:0] {
    SEL_TEMP  = 2'h0,
    SEL_OPEN  = 2'h1,
    SEL_SHORT = 2'h2
  } sel_e;

  typedef struct packed {
    logic sclk;
    logic sin;
    logic latch;
    logic oe_n;
  } link_s;

  typedef struct packed {
    logic [NUM_CH-1:0] open_fault;
    logic [NUM_CH-1:0] short_fault;
    logic              over_temp;
  } sense_s;

endpackage

// ==== design/channel_stagger.sv ====
// Staggered turn-on of the sink channels; turn-off is immediate.
// Assumes req comes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module channel_stagger
  import diag_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [NUM_CH-1:0] req,
  output logic      [NUM_CH-1:0] sink
);

  typedef struct packed {
    logic [NUM_CH-1:0][CNT_W-1:0] cnt;
    logic [NUM_CH-1:0]            sink;
  } stag_s;

  stag_s state_reg;
  stag_s state_next;

  // ****************************************
  // Per-channel delay counters
  // ****************************************
  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < NUM_CH; i++) begin
      if (!req[i]) begin
        state_next.cnt[i] = '0;
      end else if (state_reg.cnt[i] != {CNT_W{1'b1}}) begin
        state_next.cnt[i] = state_reg.cnt[i] + 1'b1;
      end
      state_next.sink[i] = req[i] &&
        (32'(state_reg.cnt[i]) >= i * STEP_CYC);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sink = state_reg.sink;

  chk_stagger_last: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sink[NUM_CH-1]) |-> $past(req[NUM_CH-1], 16))
    else $error("last channel turned on too early");
  chk_stagger_first: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(req[0]) |=> sink[0])
    else $error("first channel delayed");

endmodule
`default_nettype wire

// ==== design/led_chain_diag.sv ====
// Diagnostic sequencer of one cascaded LED sink driver.
// Assumes link pins and sense levels are asynchronous to clk.
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - With no error mode chosen, the temperature flag goes into the chain.
// - One pulse selects open report, two select short report.
// - Channels off at test time read as 1 in detailed reports.
// - Low-current diagnosis drives all channels from an all-ones pattern.
// - Displayed pattern is saved before low-current diagnosis starts.
// - Three pulses during error-detection mode enter low-current diagnosis.
// - Rising output enable ends the LED test.
// - Pulses under a high strobe after the test select the report.
// - With strobe and output enable low, the saved pattern is shown again.
// - Next shift-in after a test shifts the selected report out.
// - Each rising serial clock presents shift register LSB on serial out.
// - Channel turn-on staggers 20 ns per channel, 300 ns for the last; the code steps one 25 ns clock per channel, 375 ns for the last.
// - Reduced current on next falling enable, normal on next rising.
// - Falling strobe copies the selected report into the shift register.
// - Bit 0 of the temperature word carries the temperature flag.
// - Temperature sampled on rising enable; 0 hot, 1 normal.
module led_chain_diag
  import diag_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire diag_pkg::link_s     link_in,
  input  wire diag_pkg::sense_s    sense_in,
  output logic                     serial_out,
  output logic [15:0]              sink_channel,
  output logic                     reduced_test_current,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [3:0]          awaddr,
  input  wire logic [2:0]          awprot,
  input  wire logic                wvalid,
  output logic                     wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  output logic                     bvalid,
  input  wire logic                bready,
  output logic [1:0]               bresp,
  input  wire logic                arvalid,
  output logic                     arready,
  input  wire logic [3:0]          araddr,
  input  wire logic [2:0]          arprot,
  output logic                     rvalid,
  input  wire logic                rready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp
);

  import diag_pkg::*;

  localparam int SYNC_W = $bits(link_s) + $bits(sense_s);

  typedef struct packed {
    logic              prev_sclk;
    logic              prev_latch;
    logic              prev_oe_n;
    logic [NUM_CH-1:0] shift_reg;
    logic [NUM_CH-1:0] data_reg;
    logic [NUM_CH-1:0] saved_reg;
    mode_e             mode;
    sel_e              sel;
    logic [2:0]        pulse_cnt;
    logic              temp_ok;
    logic [NUM_CH-1:0] open_rpt;
    logic [NUM_CH-1:0] short_rpt;
    logic              reduced;
    logic              sout;
    logic              enable;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } state_s;

  state_s            state_reg;
  state_s            state_next;
  link_s             lnk;
  sense_s            sns;
  link_s             pin_lnk;
  link_s             sync_lnk;
  logic [NUM_CH-1:0] disp;
  logic [NUM_CH-1:0] sink_req;
  logic              sclk_rise;
  logic              latch_rise;
  logic              latch_fall;
  logic              oe_fall;
  logic              oe_rise;
  logic              wr_go;
  logic              rd_go;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Enable travels inverted so a cleared synchroniser reads as idle
  assign pin_lnk = '{sclk: link_in.sclk, sin: link_in.sin,
                     latch: link_in.latch, oe_n: !link_in.oe_n};

  pin_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({pin_lnk, sense_in}),
    .sync_out ({sync_lnk, sns})
  );

  assign lnk = '{sclk: sync_lnk.sclk, sin: sync_lnk.sin,
                 latch: sync_lnk.latch, oe_n: !sync_lnk.oe_n};

  assign sclk_rise = lnk.sclk && !state_reg.prev_sclk;
  assign latch_rise = lnk.latch && !state_reg.prev_latch;
  assign latch_fall = !lnk.latch && state_reg.prev_latch;
  assign oe_fall = !lnk.oe_n && state_reg.prev_oe_n;
  assign oe_rise = lnk.oe_n && !state_reg.prev_oe_n;

  // ****************************************
  // Display source and channel gating
  // ****************************************
  always_comb begin
    if (state_reg.mode == MODE_ARMED || state_reg.mode == MODE_TEST) begin
      disp = ALL_ONES;
    end else begin
      disp = state_reg.data_reg;
    end
    sink_req = disp & {NUM_CH{!lnk.oe_n && state_reg.enable}};
  end

  channel_stagger u_stagger (
    .clk   (clk),
    .rst_n (rst_n),
    .req   (sink_req),
    .sink  (sink_channel)
  );

  // ****************************************
  // Bus handshakes
  // ****************************************
  assign wr_go = awvalid && wvalid && !state_reg.bvalid;
  assign rd_go = arvalid && !state_reg.rvalid;
  assign awready = wr_go;
  assign wready = wr_go;
  assign arready = rd_go;

  // ****************************************
  // Sequencer and register file
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.prev_sclk = lnk.sclk;
    state_next.prev_latch = lnk.latch;
    state_next.prev_oe_n = lnk.oe_n;

    // Chain shift on every serial clock rise
    if (sclk_rise) begin
      state_next.sout = state_reg.shift_reg[0];
      state_next.shift_reg = {lnk.sin, state_reg.shift_reg[NUM_CH-1:1]};
      if (lnk.latch && state_reg.pulse_cnt != PULSES_MAX) begin
        state_next.pulse_cnt = state_reg.pulse_cnt + 3'h1;
      end
    end

    // Strobe rise latches new display data in normal mode only
    if (latch_rise) begin
      state_next.pulse_cnt = '0;
      if (state_reg.mode == MODE_NORMAL) begin
        state_next.data_reg = state_reg.shift_reg;
      end
    end

    // Strobe fall decodes the mode pulses
    if (latch_fall) begin
      state_next.pulse_cnt = '0;
      unique case (state_reg.pulse_cnt)
        PULSES_OPEN: begin
          state_next.sel = SEL_OPEN;
          state_next.shift_reg = state_reg.open_rpt;
        end
        PULSES_SHORT: begin
          state_next.sel = SEL_SHORT;
          state_next.shift_reg = state_reg.short_rpt;
        end
        default: begin
          state_next.sel = SEL_TEMP;
          state_next.shift_reg = {TEMP_FILL, state_reg.temp_ok};
        end
      endcase
      if (state_reg.mode == MODE_DONE) begin
        state_next.mode = MODE_NORMAL;
        state_next.data_reg = state_reg.saved_reg;
      end else if (state_reg.mode == MODE_NORMAL &&
                   state_reg.pulse_cnt == PULSES_LOWCUR) begin
        state_next.mode = MODE_ARMED;
        state_next.saved_reg = state_reg.data_reg;
      end
    end

    // Output enable fall starts the reduced-current test
    if (oe_fall && state_reg.mode == MODE_ARMED) begin
      state_next.mode = MODE_TEST;
      state_next.reduced = 1'b1;
    end

    // Output enable rise samples status and ends a test
    if (oe_rise) begin
      state_next.temp_ok = !sns.over_temp;
      state_next.open_rpt = ~(sns.open_fault & disp);
      state_next.short_rpt = ~(sns.short_fault & disp);
      if (state_reg.mode == MODE_TEST) begin
        state_next.mode = MODE_DONE;
        state_next.reduced = 1'b0;
      end
    end

    // Write channel
    if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      if (awaddr == OFS_CTRL) begin
        if (wstrb[0]) begin
          state_next.enable = wdata[CTRL_EN_BIT];
        end
      end else if (awaddr != OFS_STATUS && awaddr != OFS_DISPLAY &&
                   awaddr != OFS_REPORT) begin
        state_next.bresp = RESP_SLVERR;
      end
    end

    // Read channel
    if (state_reg.rvalid && rready) begin
      state_next.rvalid = 1'b0;
    end
    if (rd_go) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      state_next.rdata = '0;
      unique case (araddr)
        OFS_CTRL: begin
          state_next.rdata[CTRL_EN_BIT] = state_reg.enable;
        end
        OFS_STATUS: begin
          state_next.rdata = 32'({state_reg.mode, state_reg.sel,
                                  state_reg.reduced, state_reg.temp_ok});
        end
        OFS_DISPLAY: begin
          state_next.rdata = 32'(state_reg.data_reg);
        end
        OFS_REPORT: begin
          state_next.rdata = {state_reg.short_rpt, state_reg.open_rpt};
        end
        default: begin
          state_next.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.prev_oe_n <= 1'b1;
      state_reg.shift_reg <= ALL_ONES;
      state_reg.open_rpt <= ALL_ONES;
      state_reg.short_rpt <= ALL_ONES;
      state_reg.temp_ok <= 1'b1;
      state_reg.mode <= MODE_NORMAL;
      state_reg.sel <= SEL_TEMP;
      state_reg.enable <= CTRL_EN_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign serial_out = state_reg.sout;
  assign reduced_test_current = state_reg.reduced;
  assign bvalid = state_reg.bvalid;
  assign bresp = state_reg.bresp;
  assign rvalid = state_reg.rvalid;
  assign rdata = state_reg.rdata;
  assign rresp = state_reg.rresp;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_serial_lsb: assert property (
    sclk_rise |=> serial_out == $past(state_reg.shift_reg[0]))
    else $error("serial out is not the previous shift LSB");
  chk_lowcur_ones: assert property (
    state_reg.mode == MODE_TEST && !lnk.oe_n && state_reg.enable
      |-> sink_req == ALL_ONES)
    else $error("test pattern is not all ones");
  chk_lowcur_entry: assert property (
    latch_fall && state_reg.mode == MODE_NORMAL &&
      state_reg.pulse_cnt == PULSES_LOWCUR
      |=> state_reg.mode == MODE_ARMED &&
          state_reg.saved_reg == $past(state_reg.data_reg))
    else $error("low-current entry missed");
  chk_reduced_on: assert property (
    oe_fall && state_reg.mode == MODE_ARMED
      |=> reduced_test_current ##0 state_reg.mode == MODE_TEST)
    else $error("reduced current not applied");
  chk_test_end: assert property (
    oe_rise && state_reg.mode == MODE_TEST
      |=> !reduced_test_current && state_reg.mode == MODE_DONE)
    else $error("test not ended on enable rise");
  chk_off_ones: assert property (
    oe_rise |=> (~$past(disp) & ~(state_reg.open_rpt &
                 state_reg.short_rpt)) == '0)
    else $error("off channel reported as fault");
  chk_temp_sample: assert property (
    oe_rise |=> state_reg.temp_ok == !$past(sns.over_temp))
    else $error("temperature flag not sampled");
  chk_open_load: assert property (
    latch_fall && state_reg.pulse_cnt == PULSES_OPEN
      |=> state_reg.shift_reg == $past(state_reg.open_rpt))
    else $error("open report not loaded");
  chk_temp_word: assert property (
    latch_fall && state_reg.pulse_cnt == '0
      |=> state_reg.shift_reg == {TEMP_FILL, $past(state_reg.temp_ok)})
    else $error("temperature word wrong");
  chk_restore_pat: assert property (
    latch_fall && state_reg.mode == MODE_DONE
      |=> state_reg.data_reg == $past(state_reg.saved_reg))
    else $error("saved pattern not restored");
  chk_pulse_clear: assert property (
    latch_fall |=> state_reg.pulse_cnt == '0)
    else $error("pulse count not cleared");
  chk_sink_gate: assert property (
    lnk.oe_n |-> sink_req == '0)
    else $error("sink active with enable high");

  cov_lowcur: cover property (latch_fall && state_reg.mode == MODE_NORMAL
    && state_reg.pulse_cnt == PULSES_LOWCUR);
  cov_test_end: cover property (oe_rise && state_reg.mode == MODE_TEST);
  cov_short_rpt: cover property (latch_fall &&
    state_reg.pulse_cnt == PULSES_SHORT);
  cov_restore: cover property (latch_fall && state_reg.mode == MODE_DONE);

endmodule
`default_nettype wire

// ==== design/pin_sync.sv ====
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes every bit is a slow level relative to clk.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_s;

  sync_s state_reg;
  sync_s state_next;

  always_comb begin
    state_next.meta = async_in;
    state_next.sync = state_reg.meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.sync;

endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
// Host side model: drives the serial chain pins of one device.
// Assumes clk is the 40 MHz block clock; pins change after its edges.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic            clk,
  input  wire logic            serial_out,
  output var  diag_pkg::link_s link
);
  import diag_pkg::*;
  // ****************************************
  // Pin sequences
  // ****************************************
  localparam int HALF = 4;
  initial link = '{sclk: 1'b0, sin: 1'b0, latch: 1'b0, oe_n: 1'b1};
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Sixteen clocks a device, LSB first; sin inverted between frames
  task automatic shift_word(input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    for (int b = 0; b < NUM_CH; b++) begin
      link.sin <= d[b];
      tick(HALF);
      link.sclk <= 1'b1;
      tick(HALF);
      q[b] = serial_out;
      link.sclk <= 1'b0;
    end
    link.sin <= ~d[NUM_CH-1];
  endtask
  // Strobe high, k mode clocks, strobe low
  task automatic latch_pulse(input int k);
    @(posedge clk);
    link.latch <= 1'b1;
    tick(2*HALF);
    repeat (k) begin
      link.sclk <= 1'b1;
      tick(HALF);
      link.sclk <= 1'b0;
      tick(HALF);
    end
    link.latch <= 1'b0;
    tick(2*HALF);
  endtask
  task automatic set_oe(input logic v);
    @(posedge clk);
    link.oe_n <= v;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench of the diagnostic sequencer.
// Assumes host_model drives the link pins; bench drives bus and sense.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import diag_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  sense_s      sense = '0;
  link_s       link;
  logic        serial_out, reduced_test_current;
  logic [15:0] sink_channel;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  awaddr = '0, araddr = '0;
  logic [3:0]  wstrb = 4'hF;
  logic [2:0]  awprot = '0, arprot = '0;
  logic [31:0] wdata = '0, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          num_errors = 0;
  int          n_compared = 0;
  typedef struct packed {
    logic [15:0] data;
    logic        hot;
    logic [15:0] sink;
  } row_s;
  localparam row_s ROWS [4] = '{'{16'h0001, 1'b0, 16'h0001},
    '{16'h8000, 1'b1, 16'h8000}, '{16'hA5C3, 1'b0, 16'hA5C3},
    '{16'hFFFF, 1'b1, 16'hFFFF}};
  always #12.5 clk = ~clk;
  host_model host (.clk(clk), .serial_out(serial_out), .link(link));
  led_chain_diag uut (.clk(clk), .rst_n(rst_n), .link_in(link),
    .sense_in(sense), .serial_out(serial_out), .sink_channel(sink_channel),
    .reduced_test_current(reduced_test_current), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic lit(input int n, input logic [15:0] exp);
    host.set_oe(1'b0);
    repeat (n) @(posedge clk);
    #1 cmp(sink_channel, exp);
    host.set_oe(1'b1);
    repeat (8) @(posedge clk);
  endtask
  task automatic conclude();
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    logic [15:0] q, eo;
    logic        flag;
    logic [31:0] d, e;
    logic [1:0]  r;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 cmp({serial_out, reduced_test_current, sink_channel}, 0);
    rd(OFS_CTRL, d, r);
    cmp({r, d}, 32'h1);
    rd(OFS_STATUS, d, r);
    cmp({r, d}, 32'h1);
    rd(4'h2, d, r);
    cmp({r, d}, {RESP_SLVERR, 32'h0});
    wr(4'h6, 32'h0, r);
    cmp(r, RESP_SLVERR);
    wr(OFS_STATUS, 32'h0, r);
    cmp(r, RESP_OKAY);
    eo = 16'hFFFF;
    flag = 1'b1;
    foreach (ROWS[i]) begin
      host.shift_word(ROWS[i].data, q);
      sense.over_temp <= ROWS[i].hot;
      #1 cmp(q, eo);
      host.latch_pulse(0);
      eo = {15'h7FFF, flag};
      lit(24, ROWS[i].sink);
      flag = ~ROWS[i].hot;
    end
    rd(OFS_STATUS, d, r);
    cmp(d, {31'h0, flag});
    wr(OFS_CTRL, 32'h0, r);
    lit(24, 16'h0000);
    wr(OFS_CTRL, 32'h1, r);
    host.set_oe(1'b0);
    for (int k = 1; k < 22; k++) begin
      @(posedge clk);
      e = (k < 3) ? 32'h0 : (32'h1 << (k - 2)) - 32'h1;
      #1 cmp(sink_channel, (e > 32'hFFFF) ? 32'hFFFF : e);
    end
    host.set_oe(1'b1);
    repeat (4) @(posedge clk);
    #1 cmp(sink_channel, 0);
    host.shift_word(16'h00F0, q);
    host.latch_pulse(0);
    sense <= '{open_fault: 16'h0130, short_fault: 16'h0050, over_temp: 1'b0};
    lit(80, 16'h00F0);
    host.latch_pulse(1);
    host.shift_word(16'h00F0, q);
    #1 cmp(q, 16'hFFCF);
    host.latch_pulse(2);
    host.shift_word(16'h00F0, q);
    #1 cmp(q, 16'hFFAF);
    rd(OFS_REPORT, d, r);
    cmp(d, 32'hFFAF_FFCF);
    host.shift_word(16'h0F0F, q);
    host.latch_pulse(3);
    sense <= '{open_fault: 16'h0011, short_fault: 16'h0100, over_temp: 1'b0};
    #1 cmp(reduced_test_current, 0);
    host.set_oe(1'b0);
    repeat (24) @(posedge clk);
    #1 cmp({reduced_test_current, sink_channel}, 32'h1FFFF);
    repeat (56) @(posedge clk);
    host.set_oe(1'b1);
    repeat (8) @(posedge clk);
    #1 cmp(reduced_test_current, 0);
    rd(OFS_STATUS, d, r);
    cmp(d[5:4], 2'h2);
    host.latch_pulse(1);
    lit(24, 16'h0F0F);
    host.shift_word(16'h0F0F, q);
    #1 cmp(q, 16'hFFEE);
    rd(OFS_DISPLAY, d, r);
    cmp({r, d}, 32'h0F0F);
    rd(OFS_STATUS, d, r);
    cmp({r, d}, 32'h5);
    wstrb <= 4'hE;
    wr(OFS_CTRL, 32'h0, r);
    rd(OFS_CTRL, d, r);
    cmp({r, d}, 32'h1);
    wstrb <= 4'hF;
    wr(OFS_CTRL, 32'h0, r);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 cmp({serial_out, reduced_test_current, sink_channel}, 0);
    rd(OFS_CTRL, d, r);
    cmp({r, d}, 32'h1);
    rd(OFS_STATUS, d, r);
    cmp({r, d}, 32'h1);
    conclude();
  end
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
